// ===== hw/i2c_master_end.sv
// Two-wire bus master end, commanded over Avalon-MM
`timescale 1ns/10ps
`default_nettype none
module i2c_master_end #(
    parameter int QUARTER_CYC = i2c_link_pkg::SCL_QUARTER_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    i2c_link_if.host link,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    import i2c_link_pkg::*;

    master_state_t state_q, state_d;
    logic [1:0] ph_q, ph_d;
    logic [3:0] bit_q, bit_d;
    logic [8:0] sr_q, sr_d;
    logic [8:0] rx_q, rx_d;
    logic stop_q, stop_d;
    logic scl_low_q, scl_low_d;
    logic sda_low_q, sda_low_d;
    logic [7:0] tick_q;
    logic rd_ack_q;
    logic [31:0] rdata_q;
    logic scl_s1_q, scl_s2_q;
    logic sda_s1_q, sda_s2_q;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            scl_s1_q <= link.scl;
            scl_s2_q <= scl_s1_q;
            sda_s1_q <= link.sda;
            sda_s2_q <= sda_s1_q;
        end
    end

    wire busy = (state_q != M_IDLE);
    wire is_cmd = (avs_address_i == CMD_OFS);
    wire cmd_take = avs_write_i & is_cmd & !busy;
    // Released clock still low means the slave stretches it
    wire stretched = !scl_low_q & !scl_s2_q;
    wire tick = (tick_q == 8'(QUARTER_CYC - 1)) & !stretched;
    wire [31:0] status_rd = {16'h0000, rx_q[8:1], 6'h00, rx_q[0], busy};
    wire [31:0] rd_mux = (avs_address_i == HSTAT_OFS) ? status_rd : 32'h0000_0000;

    always_comb begin
        state_d = state_q;
        ph_d = ph_q;
        bit_d = bit_q;
        sr_d = sr_q;
        rx_d = rx_q;
        stop_d = stop_q;
        scl_low_d = scl_low_q;
        sda_low_d = sda_low_q;
        if (cmd_take) begin
            stop_d = avs_writedata_i[CMD_STOP_BIT];
            sr_d = avs_writedata_i[CMD_READ_BIT] ? {8'hff, avs_writedata_i[CMD_NACK_BIT]}
                                                 : {avs_writedata_i[7:0], 1'b1};
            state_d = avs_writedata_i[CMD_START_BIT] ? M_START : M_BITS;
            ph_d = 2'd0;
            bit_d = 4'h0;
        end else if (tick) begin
            ph_d = 2'(ph_q + 2'd1);
            case (state_q)
                M_START: begin
                    case (ph_q)
                        2'd0: sda_low_d = 1'b0;
                        2'd1: scl_low_d = 1'b0;
                        2'd2: sda_low_d = 1'b1;
                        default: begin
                            scl_low_d = 1'b1;
                            state_d = M_BITS;
                        end
                    endcase
                end
                M_BITS: begin
                    case (ph_q)
                        2'd0: sda_low_d = !sr_q[8];
                        2'd1: scl_low_d = 1'b0;
                        2'd2: rx_d = {rx_q[7:0], sda_s2_q};
                        default: begin
                            scl_low_d = 1'b1;
                            sr_d = {sr_q[7:0], 1'b1};
                            bit_d = 4'(bit_q + 4'h1);
                            if (bit_q == ACK_CNT) begin
                                state_d = stop_q ? M_STOP : M_IDLE;
                            end
                        end
                    endcase
                end
                M_STOP: begin
                    case (ph_q)
                        2'd0: sda_low_d = 1'b1;
                        2'd1: scl_low_d = 1'b0;
                        2'd2: sda_low_d = 1'b0;
                        default: state_d = M_IDLE;
                    endcase
                end
                default: state_d = M_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= M_IDLE;
            ph_q <= 2'd0;
            bit_q <= 4'h0;
            sr_q <= 9'h1ff;
            rx_q <= 9'h000;
            stop_q <= 1'b0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ph_q <= ph_d;
            bit_q <= bit_d;
            sr_q <= sr_d;
            rx_q <= rx_d;
            stop_q <= stop_d;
            scl_low_q <= scl_low_d;
            sda_low_q <= sda_low_d;
        end
    end

    // Divider for the link clock; frozen while the slave stretches
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_q <= 8'h00;
        end else if (cmd_take || tick) begin
            tick_q <= 8'h00;
        end else if (!stretched) begin
            tick_q <= 8'(tick_q + 8'h01);
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            rd_ack_q <= avs_read_i & !rd_ack_q;
            rdata_q <= (avs_read_i & !rd_ack_q) ? rd_mux : rdata_q;
        end
    end

    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = (avs_write_i & is_cmd & busy) | (avs_read_i & !rd_ack_q);
    assign link.host_scl_o = 1'b0;
    assign link.host_scl_oe = scl_low_q;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe = sda_low_q;
endmodule
`default_nettype wire

// ===== hw/i2c_slave_end.sv
// Two-wire slave end with its own register port
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_end (
    input wire logic core_clk_i,
    input wire logic rst_i,
    i2c_link_if.device link,
    input wire logic [i2c_link_pkg::REG_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [i2c_link_pkg::REG_W-1:0] reg_wdata_i,
    output logic [i2c_link_pkg::REG_W-1:0] reg_rdata_o,
    output logic irq_o
);
    import i2c_link_pkg::*;

    slave_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sr_q, sr_d;
    logic sda_low_q, sda_low_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] addr_q, addr_d;
    logic [7:0] data_q, data_d;
    logic byte_complete_flag_q, byte_complete_flag_d;
    logic address_matched_flag_q, address_matched_flag_d;
    logic bus_busy_flag_q, bus_busy_flag_d;
    logic master_read_flag_q, master_read_flag_d;
    logic ack_received_n_q, ack_received_n_d;
    logic ev_d;
    logic irq_q;
    logic [7:0] rdata_q;
    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;

    // Bus sampling; only the second and third stages are looked at
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else begin
            scl_s1_q <= link.scl;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= link.sda;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    wire scl_rise = scl_s2_q & !scl_s3_q;
    wire scl_fall = !scl_s2_q & scl_s3_q;
    wire scl_high = scl_s2_q & scl_s3_q;
    wire start_det = scl_high & sda_s3_q & !sda_s2_q;
    wire stop_det = scl_high & !sda_s3_q & sda_s2_q;
    wire ctrl_wr = reg_wr_i & (reg_addr_i == CTRL_OFS);
    wire addr_wr = reg_wr_i & (reg_addr_i == OWN_ADDR_OFS);
    wire data_wr = reg_wr_i & (reg_addr_i == DATA_OFS);
    wire data_rd = reg_rd_i & (reg_addr_i == DATA_OFS);
    wire enabled = ctrl_q[CTRL_EN_BIT];
    wire tx_mode = ctrl_q[CTRL_TX_BIT];
    wire [6:0] own_addr = addr_q[7:1];
    wire [7:0] sr_next = {sr_q[6:0], sda_s2_q};
    wire [3:0] cnt_inc = 4'(cnt_q + 4'h1);
    wire [7:0] ctrl_rd = ctrl_q & 8'h98;
    wire [7:0] status_rd = {byte_complete_flag_q, address_matched_flag_q, bus_busy_flag_q,
                            2'b00, master_read_flag_q, 1'b0, ack_received_n_q};
    wire [7:0] rd_mux = (reg_addr_i == OWN_ADDR_OFS) ? {own_addr, 1'b0} :
                        (reg_addr_i == CTRL_OFS) ? ctrl_rd :
                        (reg_addr_i == STAT_OFS) ? status_rd :
                        (reg_addr_i == DATA_OFS) ? data_q : 8'h00;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        sr_d = sr_q;
        sda_low_d = sda_low_q;
        ctrl_d = ctrl_wr ? reg_wdata_i : ctrl_q;
        addr_d = addr_wr ? reg_wdata_i : addr_q;
        data_d = data_wr ? reg_wdata_i : data_q;
        byte_complete_flag_d = byte_complete_flag_q;
        address_matched_flag_d = ctrl_wr ? 1'b0 : address_matched_flag_q;
        bus_busy_flag_d = bus_busy_flag_q;
        master_read_flag_d = master_read_flag_q;
        ack_received_n_d = ack_received_n_q;
        ev_d = 1'b0;
        if (!enabled) begin
            // Both lines left alone; nothing matched or acknowledged
            state_d = S_IDLE;
            sda_low_d = 1'b0;
            bus_busy_flag_d = 1'b0;
        end else if (start_det) begin
            // Repeated START also lands here and restarts the address
            bus_busy_flag_d = 1'b1;
            state_d = S_ADDR;
            cnt_d = 4'h0;
            sda_low_d = 1'b0;
            byte_complete_flag_d = 1'b0;
        end else if (stop_det) begin
            bus_busy_flag_d = 1'b0;
            state_d = S_IDLE;
            sda_low_d = 1'b0;
        end else begin
            case (state_q)
                S_ADDR: begin
                    if (scl_rise) begin
                        sr_d = sr_next;
                        cnt_d = cnt_inc;
                        if (cnt_q == LAST_DATA_CNT) begin
                            if (sr_q[6:0] == own_addr) begin
                                address_matched_flag_d = 1'b1;
                                byte_complete_flag_d = 1'b1;
                                master_read_flag_d = sda_s2_q;
                                ev_d = 1'b1;
                                state_d = S_ADDR_ACK;
                            end else begin
                                address_matched_flag_d = 1'b0;
                                state_d = S_IDLE;
                            end
                        end
                    end
                end
                S_ADDR_ACK, S_RX_ACK, S_TX_ACK: begin
                    if (scl_fall && cnt_q == ACK_CNT) begin
                        if (state_q == S_ADDR_ACK) begin
                            sda_low_d = 1'b1;
                        end else if (state_q == S_RX_ACK) begin
                            sda_low_d = !ctrl_q[CTRL_ACK_BIT];
                        end else begin
                            sda_low_d = 1'b0;
                        end
                    end else if (scl_rise && cnt_q == ACK_CNT) begin
                        cnt_d = ACK_DONE_CNT;
                        if (state_q == S_TX_ACK) begin
                            ack_received_n_d = sda_s2_q;
                        end
                    end else if (scl_fall && cnt_q == ACK_DONE_CNT) begin
                        // Clock is held low from here until software acts
                        sda_low_d = 1'b0;
                        state_d = S_HOLD;
                    end
                end
                S_HOLD: begin
                    if (data_wr && tx_mode) begin
                        sr_d = reg_wdata_i;
                        sda_low_d = !reg_wdata_i[7];
                        cnt_d = 4'h0;
                        byte_complete_flag_d = 1'b0;
                        state_d = S_TX;
                    end else if (data_rd && !tx_mode) begin
                        // Dummy read frees the clock and leaves data released
                        sda_low_d = 1'b0;
                        cnt_d = 4'h0;
                        byte_complete_flag_d = 1'b0;
                        state_d = S_RX;
                    end
                end
                S_RX: begin
                    if (scl_rise) begin
                        sr_d = sr_next;
                        cnt_d = cnt_inc;
                        if (cnt_q == LAST_DATA_CNT) begin
                            data_d = sr_next;
                            byte_complete_flag_d = 1'b1;
                            address_matched_flag_d = 1'b0;
                            ev_d = 1'b1;
                            cnt_d = ACK_CNT;
                            state_d = S_RX_ACK;
                        end
                    end
                end
                S_TX: begin
                    if (scl_rise) begin
                        cnt_d = cnt_inc;
                        if (cnt_q == LAST_DATA_CNT) begin
                            byte_complete_flag_d = 1'b1;
                            address_matched_flag_d = 1'b0;
                            ev_d = 1'b1;
                            cnt_d = ACK_CNT;
                            state_d = S_TX_ACK;
                        end
                    end else if (scl_fall) begin
                        sr_d = {sr_q[6:0], 1'b0};
                        sda_low_d = !sr_q[6];
                    end
                end
                S_IDLE: begin
                    state_d = S_IDLE;
                end
                default: begin
                    state_d = S_IDLE;
                    sda_low_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= S_IDLE;
            cnt_q <= 4'h0;
            sr_q <= 8'h00;
            sda_low_q <= 1'b0;
            ctrl_q <= CTRL_RESET;
            addr_q <= ADDR_RESET;
            data_q <= DATA_RESET;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sr_q <= sr_d;
            sda_low_q <= sda_low_d;
            ctrl_q <= ctrl_d;
            addr_q <= addr_d;
            data_q <= data_d;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            byte_complete_flag_q <= 1'b0;
            address_matched_flag_q <= 1'b0;
            bus_busy_flag_q <= 1'b0;
            master_read_flag_q <= 1'b0;
            ack_received_n_q <= 1'b0;
            irq_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            byte_complete_flag_q <= byte_complete_flag_d;
            address_matched_flag_q <= address_matched_flag_d;
            bus_busy_flag_q <= bus_busy_flag_d;
            master_read_flag_q <= master_read_flag_d;
            ack_received_n_q <= ack_received_n_d;
            irq_q <= ev_d;
            rdata_q <= reg_rd_i ? rd_mux : rdata_q;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign irq_o = irq_q;
    // Open drain: value pinned low, only the enables move
    assign link.dev_scl_o = 1'b0;
    assign link.dev_scl_oe = (state_q == S_HOLD);
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = sda_low_q;
endmodule
`default_nettype wire

// ===== inc/i2c_link_if.sv
// Open-drain two-wire link joining the slave end and the master end
`timescale 1ns/10ps
`default_nettype none
interface i2c_link_if;
    logic dev_scl_o;
    logic dev_scl_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic scl;
    logic sda;
    // Pull-ups: a line is low only while some end drives a low
    assign scl = !((dev_scl_oe & !dev_scl_o) | (host_scl_oe & !host_scl_o));
    assign sda = !((dev_sda_oe & !dev_sda_o) | (host_sda_oe & !host_sda_o));
    modport device (input scl, input sda,
        output dev_scl_o, output dev_scl_oe, output dev_sda_o, output dev_sda_oe);
    modport host (input scl, input sda,
        output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// ===== inc/i2c_link_pkg.sv
// Shared constants and types for the two-wire slave and its bus master
`default_nettype none
package i2c_link_pkg;
    localparam int REG_W = 8;
    localparam logic [7:0] OWN_ADDR_OFS = 8'h20;
    localparam logic [7:0] CTRL_OFS = 8'h21;
    localparam logic [7:0] STAT_OFS = 8'h22;
    localparam logic [7:0] DATA_OFS = 8'h23;
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_TX_BIT = 4;
    localparam int CTRL_ACK_BIT = 3;
    localparam int STAT_DONE_BIT = 7;
    localparam int STAT_MATCH_BIT = 6;
    localparam int STAT_BUSY_BIT = 5;
    localparam int STAT_MREAD_BIT = 2;
    localparam int STAT_NACK_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [3:0] LAST_DATA_CNT = 4'h7;
    localparam logic [3:0] ACK_CNT = 4'h8;
    localparam logic [3:0] ACK_DONE_CNT = 4'h9;
    localparam logic [3:0] CMD_OFS = 4'h0;
    localparam logic [3:0] HSTAT_OFS = 4'h4;
    localparam int CMD_START_BIT = 8;
    localparam int CMD_STOP_BIT = 9;
    localparam int CMD_READ_BIT = 10;
    localparam int CMD_NACK_BIT = 11;
    localparam int CORE_PERIOD_NS = 40;
    localparam int SCL_PERIOD_NS = 320;
    localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CORE_PERIOD_NS);
    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_ADDR = 8'h02,
        S_ADDR_ACK = 8'h04,
        S_HOLD = 8'h08,
        S_RX = 8'h10,
        S_RX_ACK = 8'h20,
        S_TX = 8'h40,
        S_TX_ACK = 8'h80
    } slave_state_t;
    typedef enum logic [3:0] {
        M_IDLE = 4'h1,
        M_START = 4'h2,
        M_BITS = 4'h4,
        M_STOP = 4'h8
    } master_state_t;
endpackage
`default_nettype wire

// ===== test/i2c_slave_interface_bench.sv
// Self-checking bench joining the slave end and the master end
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_interface_bench;
    import i2c_link_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic irq;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_wait;
    logic wait_s;
    logic [31:0] rdat_s;
    logic [7:0] v;
    logic [31:0] m;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int irqs = 0;

    i2c_link_if i2c_link_if_i ();
    i2c_slave_end i2c_slave_end_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(i2c_link_if_i),
        .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .irq_o(irq));
    i2c_master_end #(.QUARTER_CYC(SCL_QUARTER_CYC)) i2c_master_end_i (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .link(i2c_link_if_i), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_wait));
    i2c_slave_interface_chk i2c_slave_interface_chk_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .dev_scl_o(i2c_link_if_i.dev_scl_o), .dev_scl_oe(i2c_link_if_i.dev_scl_oe),
        .dev_sda_o(i2c_link_if_i.dev_sda_o), .dev_sda_oe(i2c_link_if_i.dev_sda_oe),
        .host_scl_oe(i2c_link_if_i.host_scl_oe), .scl(i2c_link_if_i.scl),
        .sda(i2c_link_if_i.sda));

    initial begin
        forever #20 core_clk_i = ~core_clk_i;
    end

    // Midway sampling keeps edge updates out of the comparison
    always @(negedge core_clk_i) begin
        wait_s = avs_wait;
        rdat_s = avs_readdata;
        if (irq === 1'b1) begin
            irqs++;
        end
    end

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            $display("CHECK FAILED t=%0t timeout", $time);
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic s_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk_i);
        reg_wr <= 1'b0;
    endtask

    task automatic s_rd(input logic [7:0] a);
        @(posedge core_clk_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk_i);
        reg_rd <= 1'b0;
        @(negedge core_clk_i);
        v = reg_rdata;
    endtask

    task automatic m_cmd(input logic [31:0] d);
        @(posedge core_clk_i);
        avs_address <= CMD_OFS;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge core_clk_i); while (wait_s !== 1'b0);
        avs_write <= 1'b0;
    endtask

    task automatic m_idle();
        do begin
            @(posedge core_clk_i);
            avs_address <= HSTAT_OFS;
            avs_read <= 1'b1;
            do @(posedge core_clk_i); while (wait_s !== 1'b0);
            m = rdat_s;
            avs_read <= 1'b0;
        end while (m[0] !== 1'b0);
    endtask

    // Slave stretching the clock marks the end of a byte
    task automatic hold_wait();
        do @(negedge core_clk_i); while (i2c_link_if_i.dev_scl_oe !== 1'b1);
    endtask

    task automatic t_regs();
        s_rd(CTRL_OFS);
        ck(v, 8'h00);
        s_wr(OWN_ADDR_OFS, 8'h41);
        s_rd(OWN_ADDR_OFS);
        ck(v, 8'h40);
        s_wr(CTRL_OFS, 8'hFF);
        s_rd(CTRL_OFS);
        ck(v, 8'h98);
        s_rd(8'h30);
        ck(v, 8'h00);
        s_wr(CTRL_OFS, 8'h80);
        $display("test regs done");
    endtask

    task automatic t_recv();
        m_cmd(32'h0000_0140);
        hold_wait();
        s_rd(STAT_OFS);
        ck(v, 8'hE0);
        m_idle();
        ck(m[1], 1'b0);
        s_rd(DATA_OFS);
        m_cmd(32'h0000_00A5);
        hold_wait();
        s_rd(STAT_OFS);
        ck(v, 8'hA0);
        s_rd(DATA_OFS);
        ck(v, 8'hA5);
        m_idle();
        ck(m[1], 1'b0);
        s_wr(CTRL_OFS, 8'h88);
        m_cmd(32'h0000_023C);
        hold_wait();
        s_rd(DATA_OFS);
        ck(v, 8'h3C);
        m_idle();
        ck(m[1], 1'b1);
        s_rd(STAT_OFS);
        ck(v[5], 1'b0);
        ck(irqs, 3);
        $display("test receive done");
    endtask

    task automatic t_send();
        s_wr(CTRL_OFS, 8'h80);
        m_cmd(32'h0000_0141);
        hold_wait();
        s_rd(STAT_OFS);
        ck(v, 8'hE4);
        s_wr(CTRL_OFS, 8'h90);
        s_rd(STAT_OFS);
        ck(v[6], 1'b0);
        s_wr(DATA_OFS, 8'hC3);
        m_cmd(32'h0000_0400);
        hold_wait();
        m_idle();
        ck(m[15:8], 8'hC3);
        s_rd(STAT_OFS);
        ck(v, 8'hA4);
        s_wr(DATA_OFS, 8'h5E);
        m_cmd(32'h0000_0E00); // Refusal then stop
        hold_wait();
        s_rd(STAT_OFS);
        ck(v[0], 1'b1);
        s_wr(CTRL_OFS, 8'h80);
        s_rd(DATA_OFS);
        m_idle();
        ck(m[15:8], 8'h5E);
        $display("test transmit done");
    endtask

    task automatic t_other();
        m_cmd(32'h0000_0342);
        m_idle();
        ck(m[1], 1'b1);
        s_wr(CTRL_OFS, 8'h00);
        m_cmd(32'h0000_0340);
        m_idle();
        ck(m[1], 1'b1);
        s_rd(STAT_OFS);
        ck(v[5], 1'b0);
        $display("test mismatch and disable done");
    endtask

    initial begin
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_recv();
        t_send();
        t_other();
        conclude();
    end
endmodule
`default_nettype wire

// ===== test/i2c_slave_interface_chk.sv
// Wire-level assertions on the link between the slave end and the master end
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_interface_chk (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic dev_scl_o,
    input wire logic dev_scl_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic host_scl_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    scl_open_drain_a: assert property (dev_scl_o == 1'b0)
        else $error("slave clock output not low");
    sda_open_drain_a: assert property (dev_sda_o == 1'b0)
        else $error("slave data output not low");
    reset_release_a: assert property ($fell(rst_i) |-> !dev_scl_oe && !dev_sda_oe)
        else $error("slave drives a line after reset");
    // Slave may move data only while the clock is low
    sda_on_low_a: assert property ($changed(dev_sda_oe) |-> !$past(scl))
        else $error("slave data changed with clock high");
    stretch_low_a: assert property ($rose(dev_scl_oe) |-> !$past(scl))
        else $error("slave grabbed clock while high");
    no_slave_start_a: assert property ($fell(sda) && scl && $past(scl) |-> !dev_sda_oe)
        else $error("slave made a start");
    stop_release_a: assert property ($rose(sda) && scl && $past(scl) |=> !dev_sda_oe [*4])
        else $error("slave drives data after stop");
    bit_hold_a: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*4])
        else $error("slave data low too short");

    start_seen_c: cover property ($fell(sda) && scl);
    stretch_seen_c: cover property (dev_scl_oe && !host_scl_oe);
    ack_seen_c: cover property ($rose(dev_sda_oe));
endmodule
`default_nettype wire
